// File: design/ddt_pkg.sv
// Shared constants and types for the DDR3 timing controller and device
package ddt_pkg;
    localparam int CLK_NS = 40;
    localparam int CK_HALF = 4;
    localparam int TCK_NS = 2 * CK_HALF * CLK_NS;
    localparam int T_XP_NS = 6;
    localparam int T_REFI_NS = 7800;
    localparam int T_WLO_PS = 7500;
    localparam int XP_MIN = 3;
    localparam int XP_T = (T_XP_NS + TCK_NS - 1) / TCK_NS;
    localparam logic [7:0] XP_CK = 8'((XP_T > XP_MIN) ? XP_T : XP_MIN);
    localparam logic [7:0] XPDLL_CK = 8'h0a;
    localparam int PD_MAX_CK = (9 * T_REFI_NS) / TCK_NS;
    localparam int WLO_T = (T_WLO_PS / 1000) / CLK_NS;
    localparam int WLO_CYC = (WLO_T < 1) ? 1 : WLO_T;
    localparam logic [7:0] RD_PDEN_ADD = 8'h05;
    localparam logic [7:0] WR_BURST_8 = 8'h04;
    localparam logic [7:0] WR_BURST_4F = 8'h02;
    localparam logic [7:0] PRE_PDEN = 8'h02;
    localparam logic [7:0] ODTH8 = 8'h06;
    localparam logic [7:0] ODTH4 = 8'h04;
    localparam logic [7:0] WLMRD_CK = 8'h28;
    localparam logic [4:0] ODTL_SUB = 5'h02;
    localparam logic [4:0] CWN4_ADD = 5'h04;
    localparam logic [4:0] CWN8_ADD = 5'h06;
    localparam int HIST_LEN = 32;
    // Register map
    localparam logic [4:0] REG_CMD = 5'h00;
    localparam logic [4:0] REG_CFG = 5'h04;
    localparam logic [4:0] REG_ODT = 5'h08;
    localparam logic [4:0] REG_STAT = 5'h0c;
    localparam int CFG_CL_LSB = 0;
    localparam int CFG_CWL_LSB = 4;
    localparam int CFG_AL_LSB = 8;
    localparam int CFG_WR_LSB = 12;
    localparam int CFG_BC4F_BIT = 16;
    localparam logic [31:0] CFG_RST = 32'h0000_6055;
    localparam int CMD_BL8_BIT = 4;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    // Command pins: cs_n, ras_n, cas_n, we_n
    localparam logic [3:0] PIN_NOP = 4'h7;
    localparam logic [3:0] PIN_RD = 4'h5;
    localparam logic [3:0] PIN_WR = 4'h4;
    localparam logic [3:0] PIN_PRE = 4'h2;
    localparam logic [3:0] PIN_REF = 4'h1;
    localparam logic [3:0] PIN_MRS = 4'h0;
    localparam int A_AP = 10;
    localparam int A_BL8 = 12;
    localparam int A_WL = 7;
    typedef enum logic [3:0] {
        OP_NOP = 4'h0, OP_RD = 4'h1, OP_RDAP = 4'h2, OP_WR = 4'h3,
        OP_WRAP = 4'h4, OP_PRE = 4'h5, OP_REF = 4'h6, OP_PDE = 4'h7,
        OP_PDX = 4'h8, OP_WLON = 4'h9, OP_WLOFF = 4'ha, OP_DQS = 4'hb
    } ddt_op_type;
    typedef enum logic [1:0] {
        CS_IDLE = 2'b00, CS_PD = 2'b01, CS_WL = 2'b11
    } ddt_mode_type;
    typedef struct packed {
        logic ck;
        logic cke;
        logic [3:0] pin;
        logic odt;
        logic dqs;
        logic [12:0] addr;
    } ddt_pins_type;
endpackage : ddt_pkg

// File: design/ddt_link_if.sv
// Link between controller and memory device
`timescale 1ns/1ns
`default_nettype none
interface ddt_link_if;
    logic ck;
    logic cke;
    logic [3:0] pin;
    logic odt;
    logic dqs;
    logic [12:0] addr;
    logic wlFb;
    modport ctrl (output ck, cke, pin, odt, dqs, addr, input wlFb);
    modport dev (input ck, cke, pin, odt, dqs, addr, output wlFb);
endinterface : ddt_link_if
`default_nettype wire

// File: design/ddt_dev.sv
// Memory device end: termination latencies and write-leveling feedback
`timescale 1ns/1ns
`default_nettype none
module ddt_dev
    import ddt_pkg::*;
(
    // System
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // Mode register values
    input wire logic [3:0] cwl,
    input wire logic [3:0] al,
    input wire logic bc4Fixed,
    // Status
    output logic rttNom,
    output logic rttWr,
    output logic wlMode,
    output logic powerDown,
    // Link
    ddt_link_if.dev link
);
    typedef struct packed {
        ddt_pins_type s1;
        ddt_pins_type s2;
        logic ckPrev;
        logic dqsPrev;
        logic cke;
        logic [HIST_LEN-1:0] odtHist;
        logic [HIST_LEN-1:0] wrHist;
        logic [HIST_LEN-1:0] bl8Hist;
        logic rttNom;
        logic rttWr;
        logic wlMode;
        logic fb;
    } ddt_dev_type;

    ddt_dev_type r_reg, r_next;
    ddt_pins_type raw;

    assign raw = '{ck: link.ck, cke: link.cke, pin: link.pin,
                   odt: link.odt, dqs: link.dqs, addr: link.addr};

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [4:0] odtl;
        logic [4:0] cwn4;
        logic [4:0] cwn8;
        logic wr;
        logic ckRise;
        odtl = 5'({1'b0, cwl} + {1'b0, al}) - ODTL_SUB;
        cwn4 = odtl + CWN4_ADD;
        cwn8 = odtl + CWN8_ADD;
        ckRise = r_reg.s2.ck & ~r_reg.ckPrev;
        wr = r_reg.s2.cke & (r_reg.s2.pin == PIN_WR);
        r_next = r_reg;
        // Only the second stage is read below
        r_next.s1 = raw;
        r_next.s2 = r_reg.s1;
        r_next.ckPrev = r_reg.s2.ck;
        r_next.dqsPrev = r_reg.s2.dqs;
        if (ckRise) begin
            r_next.cke = r_reg.s2.cke;
            r_next.odtHist = {r_reg.odtHist[HIST_LEN-2:0], r_reg.s2.odt};
            r_next.wrHist = {r_reg.wrHist[HIST_LEN-2:0], wr};
            r_next.bl8Hist = {r_reg.bl8Hist[HIST_LEN-2:0],
                              ~bc4Fixed & r_reg.s2.addr[A_BL8]};
            if (r_reg.s2.cke && r_reg.s2.pin == PIN_MRS) begin
                r_next.wlMode = r_reg.s2.addr[A_WL];
            end
            r_next.rttNom = r_next.odtHist[odtl];
            if (r_next.wrHist[odtl]) begin
                r_next.rttWr = 1'b1;
            end else if (r_next.wrHist[cwn4] && !r_next.bl8Hist[cwn4]) begin
                r_next.rttWr = 1'b0;
            end else if (r_next.wrHist[cwn8] && r_next.bl8Hist[cwn8]) begin
                r_next.rttWr = 1'b0;
            end
        end
        // Feedback lags the strobe by the synchroniser depth
        if (r_reg.wlMode && r_reg.s2.dqs && !r_reg.dqsPrev) begin
            r_next.fb = r_reg.s2.ck;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    assign rttNom = r_reg.rttNom;
    assign rttWr = r_reg.rttWr;
    assign wlMode = r_reg.wlMode;
    assign powerDown = ~r_reg.cke;
    assign link.wlFb = r_reg.fb;
endmodule : ddt_dev
`default_nettype wire

// File: design/ddt_ctrl.sv
// Controller end: command spacing, power-down, ODT and leveling timers
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ddt_ctrl
    import ddt_pkg::*;
#(
    parameter int CK_HALF_P = CK_HALF,
    parameter int PD_MAX_P = PD_MAX_CK
) (
    // System
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // AXI4-Lite write
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Link
    ddt_link_if.ctrl link
);
    if (CK_HALF_P < 1 || CK_HALF_P > 255) begin : g_bad_half
        $error("CK_HALF_P must lie in 1..255");
    end
    if (PD_MAX_P < 2 || PD_MAX_P > 255) begin : g_bad_pd
        $error("PD_MAX_P must lie in 2..255");
    end

    typedef struct packed {
        ddt_mode_type mode;
        logic [7:0] div;
        logic ck;
        logic [3:0] pin;
        logic [12:0] addr;
        logic cke;
        logic odt;
        logic dqs;
        logic [31:0] cfg;
        logic odtReq;
        logic pend;
        ddt_op_type op;
        logic bl8;
        logic [7:0] pdenCnt;
        logic [7:0] xpCnt;
        logic [7:0] dllCnt;
        logic [7:0] odtCnt;
        logic [7:0] wlCnt;
        logic [7:0] pdCnt;
        logic fb1;
        logic fb2;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } ddt_ctl_type;

    localparam ddt_ctl_type CTL_RST = '{mode: CS_IDLE, op: OP_NOP,
        pin: PIN_NOP, cke: 1'b1, cfg: CFG_RST, default: '0};

    function automatic logic [7:0] dec8(input logic [7:0] v);
        return (v == 8'h00) ? 8'h00 : v - 8'h01;
    endfunction : dec8

    function automatic logic [7:0] max8(input logic [7:0] a,
                                        input logic [7:0] b);
        return (a > b) ? a : b;
    endfunction : max8

    ddt_ctl_type r_reg, r_next;
    logic wrTake;
    logic rdTake;

    // Both write channels are taken in one cycle, only once bvalid of the last write has cleared
    assign s_axi_awready = ce & s_axi_awvalid & s_axi_wvalid & ~r_reg.bvalid;
    assign s_axi_wready = s_axi_awready;
    assign s_axi_arready = ce & s_axi_arvalid & ~r_reg.rvalid;
    assign wrTake = s_axi_awready;
    assign rdTake = s_axi_arready;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [7:0] cl;
        logic [7:0] cwl;
        logic [7:0] al;
        logic [7:0] wr;
        logic [7:0] rl;
        logic [7:0] wl;
        logic [7:0] burst;
        logic bc4Fixed;
        logic ckFall;
        logic done;
        logic pdExit;
        cl = {4'h0, r_reg.cfg[CFG_CL_LSB +: 4]};
        cwl = {4'h0, r_reg.cfg[CFG_CWL_LSB +: 4]};
        al = {4'h0, r_reg.cfg[CFG_AL_LSB +: 4]};
        wr = {4'h0, r_reg.cfg[CFG_WR_LSB +: 4]};
        bc4Fixed = r_reg.cfg[CFG_BC4F_BIT];
        rl = al + cl;
        wl = al + cwl;
        burst = bc4Fixed ? WR_BURST_4F : WR_BURST_8;
        ckFall = 1'b0;
        done = 1'b0;
        pdExit = 1'b0;
        r_next = r_reg;
        r_next.fb1 = link.wlFb;
        r_next.fb2 = r_reg.fb1;

        // Link clock divider; pins move on the falling edge so the device
        // samples them mid-cell on the rising one
        if (r_reg.div == 8'(CK_HALF_P - 1)) begin
            r_next.div = 8'h00;
            r_next.ck = ~r_reg.ck;
            ckFall = r_reg.ck;
        end else begin
            r_next.div = r_reg.div + 8'h01;
        end

        if (ckFall) begin
            // Timers count whole link clock cycles
            r_next.pdenCnt = dec8(r_reg.pdenCnt);
            r_next.xpCnt = dec8(r_reg.xpCnt);
            r_next.dllCnt = dec8(r_reg.dllCnt);
            r_next.odtCnt = dec8(r_reg.odtCnt);
            r_next.wlCnt = dec8(r_reg.wlCnt);
            r_next.pin = PIN_NOP;
            r_next.addr = '0;
            r_next.dqs = 1'b0;
            if (r_reg.mode == CS_PD) begin
                r_next.pdCnt = r_reg.pdCnt + 8'h01;
                // Forced exit bounds the stay in power-down
                if (r_reg.pdCnt == 8'(PD_MAX_P - 1)) begin
                    pdExit = 1'b1;
                end
            end
            if (r_reg.odtReq && !r_reg.odt && r_reg.mode == CS_IDLE &&
                r_reg.dllCnt == 8'h00) begin
                r_next.odt = 1'b1;
                r_next.odtCnt = ODTH4 - 8'h01;
            end else if (!r_reg.odtReq && r_reg.odt &&
                         r_reg.odtCnt == 8'h00) begin
                r_next.odt = 1'b0;
            end
            if (r_reg.pend) begin
                unique case (r_reg.op)
                    OP_RD, OP_RDAP: begin
                        if (r_reg.mode == CS_IDLE && r_reg.xpCnt == 8'h00 &&
                            r_reg.dllCnt == 8'h00) begin
                            r_next.pin = PIN_RD;
                            r_next.addr[A_AP] = (r_reg.op == OP_RDAP);
                            r_next.addr[A_BL8] = r_reg.bl8;
                            r_next.pdenCnt = max8(r_next.pdenCnt,
                                                  rl + RD_PDEN_ADD);
                            done = 1'b1;
                        end
                    end
                    OP_WR, OP_WRAP: begin
                        if (r_reg.mode == CS_IDLE &&
                            r_reg.xpCnt == 8'h00) begin
                            r_next.pin = PIN_WR;
                            r_next.addr[A_AP] = (r_reg.op == OP_WRAP);
                            r_next.addr[A_BL8] = r_reg.bl8;
                            r_next.pdenCnt = max8(r_next.pdenCnt,
                                wl + burst + wr +
                                {7'h00, r_reg.op == OP_WRAP});
                            if (r_reg.odt || r_next.odt) begin
                                r_next.odtCnt = max8(r_next.odtCnt,
                                    ((r_reg.bl8 && !bc4Fixed) ?
                                    ODTH8 : ODTH4) - 8'h01);
                            end
                            done = 1'b1;
                        end
                    end
                    OP_PRE, OP_REF: begin
                        if (r_reg.mode == CS_IDLE && r_reg.xpCnt == 8'h00) begin
                            r_next.pin = (r_reg.op == OP_PRE) ? PIN_PRE
                                                              : PIN_REF;
                            r_next.pdenCnt = max8(r_next.pdenCnt,
                                                  PRE_PDEN);
                            done = 1'b1;
                        end
                    end
                    OP_PDE: begin
                        if (r_reg.mode == CS_IDLE && r_reg.pdenCnt == 8'h00 &&
                            r_reg.xpCnt == 8'h00) begin
                            r_next.cke = 1'b0;
                            r_next.mode = CS_PD;
                            r_next.pdCnt = 8'h00;
                            done = 1'b1;
                        end
                    end
                    OP_PDX: begin
                        if (r_reg.mode == CS_PD) begin
                            pdExit = 1'b1;
                        end
                        done = 1'b1;
                    end
                    OP_WLON: begin
                        if (r_reg.mode == CS_IDLE && r_reg.xpCnt == 8'h00) begin
                            r_next.pin = PIN_MRS;
                            r_next.addr[A_WL] = 1'b1;
                            r_next.mode = CS_WL;
                            r_next.wlCnt = WLMRD_CK;
                            done = 1'b1;
                        end
                    end
                    OP_WLOFF: begin
                        if (r_reg.mode == CS_WL) begin
                            r_next.pin = PIN_MRS;
                            r_next.mode = CS_IDLE;
                        end
                        done = 1'b1;
                    end
                    OP_DQS: begin
                        if (r_reg.mode != CS_WL) begin
                            done = 1'b1;
                        end else if (r_reg.wlCnt == 8'h00) begin
                            r_next.dqs = 1'b1;
                            done = 1'b1;
                        end
                    end
                    default: begin
                        done = 1'b1;
                    end
                endcase
            end
            if (pdExit) begin
                r_next.cke = 1'b1;
                r_next.mode = CS_IDLE;
                r_next.xpCnt = XP_CK;
                r_next.dllCnt = XPDLL_CK;
            end
            if (done) begin
                r_next.pend = 1'b0;
            end
        end

        // Register writes; a command arriving while one waits is dropped
        if (r_reg.bvalid && s_axi_bready) begin
            r_next.bvalid = 1'b0;
        end
        if (wrTake) begin
            r_next.bvalid = 1'b1;
            r_next.bresp = RESP_OK;
            unique case (s_axi_awaddr)
                REG_CMD: begin
                    if (!r_reg.pend && s_axi_wstrb[0]) begin
                        r_next.pend = 1'b1;
                        r_next.op = ddt_op_type'(s_axi_wdata[3:0]);
                        r_next.bl8 = s_axi_wdata[CMD_BL8_BIT];
                    end
                end
                REG_CFG: begin
                    for (int i = 0; i < 4; i++) begin
                        if (s_axi_wstrb[i]) begin
                            r_next.cfg[8*i +: 8] = s_axi_wdata[8*i +: 8];
                        end
                    end
                    r_next.dllCnt = XPDLL_CK;
                end
                REG_ODT: begin
                    if (s_axi_wstrb[0]) begin
                        r_next.odtReq = s_axi_wdata[0];
                    end
                end
                REG_STAT: begin
                end
                default: begin
                    r_next.bresp = RESP_ERR;
                end
            endcase
        end
        if (r_reg.rvalid && s_axi_rready) begin
            r_next.rvalid = 1'b0;
        end
        if (rdTake) begin
            r_next.rvalid = 1'b1;
            r_next.rresp = RESP_OK;
            unique case (s_axi_araddr)
                REG_CMD: r_next.rdata = {27'h0, r_reg.bl8, r_reg.op};
                REG_CFG: r_next.rdata = r_reg.cfg;
                REG_ODT: r_next.rdata = {30'h0, r_reg.odt, r_reg.odtReq};
                REG_STAT: r_next.rdata = {25'h0, r_reg.cke, r_reg.fb2,
                    r_reg.mode, r_reg.dllCnt == 8'h00,
                    r_reg.pdenCnt == 8'h00, r_reg.pend};
                default: begin
                    r_next.rdata = 32'h0;
                    r_next.rresp = RESP_ERR;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= CTL_RST;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    assign s_axi_bresp = r_reg.bresp;
    assign s_axi_bvalid = r_reg.bvalid;
    assign s_axi_rdata = r_reg.rdata;
    assign s_axi_rresp = r_reg.rresp;
    assign s_axi_rvalid = r_reg.rvalid;
    assign link.ck = r_reg.ck;
    assign link.cke = r_reg.cke;
    assign link.pin = r_reg.pin;
    assign link.odt = r_reg.odt;
    assign link.dqs = r_reg.dqs;
    assign link.addr = r_reg.addr;
endmodule : ddt_ctrl
`default_nettype wire

// File: tb/ddt_properties.sv
// Link timing checks between the controller and device ends
`timescale 1ns/1ns
`default_nettype none
module ddt_properties
    import ddt_pkg::*;
#(
    parameter int RL_P = 5,
    parameter int WL_P = 5,
    parameter int WR_P = 6,
    parameter int PD_MAX_P = 20
) (
    // System
    input wire logic clk_sys,
    input wire logic rst_n,
    // Link
    input wire logic ck,
    input wire logic cke,
    input wire logic [3:0] pin,
    input wire logic odt,
    input wire logic dqs,
    input wire logic [12:0] addr
);
    logic ckQ;
    logic ckR;
    logic ap;
    logic [7:0] rdC, wrC, preC, xpC, odtC, odtN, wlC, pdC;
    assign ckR = ck && !ckQ;
    function automatic logic [7:0] inc(input logic [7:0] v);
        return (v == 8'hff) ? v : v + 8'h01;
    endfunction : inc
    ////////////////////////////////////////////////////////////////////
    // Counters of link clock rises since each command; they saturate
    // so that a long idle stretch never looks like a fresh command
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ckQ <= 1'b0;
            ap <= 1'b0;
            rdC <= 8'hff;
            wrC <= 8'hff;
            preC <= 8'hff;
            wlC <= 8'hff;
            xpC <= 8'hff;
            odtC <= 8'h00;
            odtN <= 8'h04;
            pdC <= 8'h00;
        end else begin
            ckQ <= ck;
            xpC <= !cke ? 8'h00 : (ckR ? inc(xpC) : xpC);
            pdC <= cke ? 8'h00 : (ckR ? inc(pdC) : pdC);
            odtC <= !odt ? 8'h00 : (ckR ? inc(odtC) : odtC);
            if (!odt) begin
                odtN <= 8'h04;
            end else if (ckR && pin == PIN_WR && addr[A_BL8]) begin
                odtN <= 8'h06;
            end
            if (ckR) begin
                rdC <= (pin == PIN_RD) ? 8'h00 : inc(rdC);
                wrC <= (pin == PIN_WR) ? 8'h00 : inc(wrC);
                preC <= (pin == PIN_PRE || pin == PIN_REF) ? 8'h00 : inc(preC);
                wlC <= (pin == PIN_MRS && addr[A_WL]) ? 8'h00 : inc(wlC);
                if (pin == PIN_WR) begin
                    ap <= addr[A_AP];
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // Counts are taken half a clock before the registering rise
    property p_rdpden;
        $fell(cke) |-> rdC >= 8'(RL_P + 4);
    endproperty
    a_rdpden: assert property (p_rdpden) else $error("read to pd early");
    property p_wrpden;
        $fell(cke) |-> wrC >= 8'(WL_P + WR_P + 3) + {7'h00, ap};
    endproperty
    a_wrpden: assert property (p_wrpden) else $error("write to pd early");
    property p_prepden;
        $fell(cke) |-> preC >= 8'h01;
    endproperty
    a_prepden: assert property (p_prepden) else $error("pre to pd early");
    property p_xp;
        ckR && pin != PIN_NOP |-> xpC >= 8'h03;
    endproperty
    a_xp: assert property (p_xp) else $error("command too soon after exit");
    property p_xpdll;
        ckR && pin == PIN_RD |-> xpC >= 8'h0a;
    endproperty
    a_xpdll: assert property (p_xpdll) else $error("read before dll");
    property p_odtdll;
        $rose(odt) |-> xpC >= 8'h0a;
    endproperty
    a_odtdll: assert property (p_odtdll) else $error("odt before dll");
    property p_odth;
        $fell(odt) |-> odtC >= odtN;
    endproperty
    a_odth: assert property (p_odth) else $error("odt high too short");
    property p_wlmrd;
        $rose(dqs) |-> wlC >= 8'h27;
    endproperty
    a_wlmrd: assert property (p_wlmrd) else $error("strobe too early");
    property p_pdmax;
        !cke |-> pdC <= 8'(PD_MAX_P + 1);
    endproperty
    a_pdmax: assert property (p_pdmax) else $error("power-down too long");
    property p_edge;
        $changed(cke) || $changed(odt) || $changed(pin) || $changed(dqs)
            |-> $fell(ck);
    endproperty
    a_edge: assert property (p_edge) else $error("link off clock fall");
endmodule : ddt_properties
`default_nettype wire

// File: tb/test_ddr3_pd_odt_wl_timing.sv
// Bench joining controller and device over the link, driven over AXI
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) \
    begin \
        totalChecks++; \
        if ((a) !== (b)) begin \
            miscompares++; \
            $display("wrong value at %0t: got %0h want %0h", $time, a, b); \
        end \
    end
module test_ddr3_pd_odt_wl_timing
    import ddt_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [4:0] awAddr = '0, arAddr = '0;
    logic [31:0] wData = '0, rData, gotData;
    logic [3:0] wStrb = 4'hf;
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
    logic arValid = 1'b0, rReady = 1'b0;
    logic awReady, wReady, bValid, arReady, rValid;
    logic [1:0] bResp, rResp, gotResp;
    logic rttNom, rttWr, powerDown;
    logic ckQ = 1'b0;
    int ckRises = 0, miscompares = 0, totalChecks = 0, d, h;
    ddt_op_type ops [6] = '{OP_RD, OP_RDAP, OP_WR, OP_WRAP, OP_PRE, OP_REF};
    always #20 clk_sys = ~clk_sys;
    ddt_link_if link();
    always @(posedge clk_sys) begin
        ckQ <= link.ck;
        if (link.ck && !ckQ) ckRises <= ckRises + 1;
    end
    ////////////////////////////////////////////////////////////////////
    ddt_ctrl #(.PD_MAX_P(20)) u_ddt_ctrl (.clk_sys(clk_sys), .rst_n(rst_n),
        .ce(ce), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .link(link));
    ddt_dev u_ddt_dev (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
        .cwl(4'h5), .al(4'h0), .bc4Fixed(1'b0), .rttNom(rttNom),
        .rttWr(rttWr), .wlMode(), .powerDown(powerDown), .link(link));
    ddt_properties #(.PD_MAX_P(20)) u_ddt_properties (.clk_sys(clk_sys),
        .rst_n(rst_n), .ck(link.ck), .cke(link.cke), .pin(link.pin),
        .odt(link.odt), .dqs(link.dqs), .addr(link.addr));
    ////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        awAddr <= a;
        wData <= v;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        do @(negedge clk_sys); while (!(awReady === 1'b1 && wReady === 1'b1));
        @(posedge clk_sys);
        awValid <= 1'b0;
        wValid <= 1'b0;
        do @(negedge clk_sys); while (bValid !== 1'b1);
        gotResp = bResp;
        @(posedge clk_sys);
        bReady <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a);
        @(posedge clk_sys);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do @(negedge clk_sys); while (arReady !== 1'b1);
        @(posedge clk_sys);
        arValid <= 1'b0;
        do @(negedge clk_sys); while (rValid !== 1'b1);
        gotData = rData;
        gotResp = rResp;
        @(posedge clk_sys);
        rReady <= 1'b0;
    endtask : rd
    // Commands may wait on timers, so poll until nothing pends
    task automatic cmd(input ddt_op_type op, input logic b);
        wr(REG_CMD, {27'h0, b, op});
        do rd(REG_STAT); while (gotData[0] !== 1'b0);
    endtask : cmd
    // Link clock rises to termination change, and rises it stays on
    task automatic span(input logic s, output int dl, output int hi);
        int t;
        wait (s ? (link.pin === PIN_WR) : (link.odt === 1'b1));
        t = ckRises;
        wait ((s ? rttWr : rttNom) === 1'b1);
        dl = ckRises - t;
        t = ckRises;
        wait ((s ? rttWr : rttNom) === 1'b0);
        hi = ckRises - t;
    endtask : span
    task automatic summarize();
        if (miscompares == 0 && totalChecks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(REG_CFG);
        `CHK(gotData, CFG_RST)
        rd(5'h10);
        `CHK(gotResp, RESP_ERR)
        wr(5'h14, 32'h0);
        `CHK(gotResp, RESP_ERR)
        fork
            begin
                wr(REG_ODT, 32'h1);
                wait (link.odt === 1'b1);
                wr(REG_ODT, 32'h0);
            end
            span(1'b0, d, h);
        join
        `CHK(d inside {[3:4]}, 1'b1)
        `CHK(h, 4)
        wr(REG_ODT, 32'h1);
        fork
            cmd(OP_WR, 1'b1);
            span(1'b1, d, h);
        join
        `CHK(d inside {[3:4]}, 1'b1)
        `CHK(h, 6)
        fork
            cmd(OP_WR, 1'b0);
            span(1'b1, d, h);
        join
        `CHK(h, 4)
        wr(REG_ODT, 32'h0);
        foreach (ops[i]) begin
            cmd(ops[i], 1'b1);
            cmd(OP_PDE, 1'b0);
            `CHK({gotData[6], gotData[4:3]}, 3'b001)
            cmd(OP_PDX, 1'b0);
            rd(REG_STAT);
            `CHK(gotData[2], 1'b0)
        end
        wr(REG_ODT, 32'h1);
        wait (link.odt === 1'b1);
        rd(REG_STAT);
        `CHK(gotData[2], 1'b1)
        wr(REG_ODT, 32'h0);
        cmd(OP_PDE, 1'b0);
        repeat (16) @(posedge clk_sys);
        `CHK(powerDown, 1'b1)
        repeat (2 * CK_HALF * 22) @(posedge clk_sys);
        rd(REG_STAT);
        `CHK({gotData[6], gotData[4:3], powerDown}, 4'b1000)
        cmd(OP_WLON, 1'b0);
        `CHK(gotData[4:3], 2'b11)
        cmd(OP_DQS, 1'b0);
        repeat (16) @(posedge clk_sys);
        rd(REG_STAT);
        `CHK(gotData[5], 1'b0)
        cmd(OP_WLOFF, 1'b0);
        rd(REG_CMD);
        `CHK(gotData[4:0], {1'b0, OP_WLOFF})
        summarize();
    end
    initial begin
        repeat (40000) @(posedge clk_sys);
        miscompares++;
        summarize();
    end
endmodule : test_ddr3_pd_odt_wl_timing
`default_nettype wire
